/* File: verilog/pcr_map.vh */
// Register offsets, reset values and bus address of the second-PLL and output bank.
`ifndef PCR_MAP_VH
`define PCR_MAP_VH
`define PCR_OFF_FIRST 8'h16
`define PCR_OFF_LAST 8'h24
`define PCR_OFF_STEP_DELTA 8'h16
`define PCR_OFF_PERIOD_LOW 8'h17
`define PCR_OFF_PLL_B_CTRL 8'h18
`define PCR_OFF_CHARGE_PUMP 8'h19
`define PCR_OFF_REF_DIV 8'h1a
`define PCR_OFF_OUT_DIV 8'h1b
`define PCR_OFF_PLL_OP 8'h1c
`define PCR_OFF_RSVD_A 8'h1d
`define PCR_OFF_EN_FREQ 8'h1e
`define PCR_OFF_B_STOP_LOOP 8'h1f
`define PCR_OFF_B_EN_FREQ 8'h20
`define PCR_OFF_C_STOP 8'h21
`define PCR_OFF_RSVD_B 8'h22
`define PCR_OFF_SRC_SEL 8'h23
`define PCR_OFF_PWR_FREERUN 8'h24
`define PCR_RST_STEP_DELTA 8'h00
`define PCR_RST_PERIOD_LOW 8'h00
`define PCR_RST_PLL_B_CTRL 8'h0e
`define PCR_RST_CHARGE_PUMP 8'h14
`define PCR_RST_REF_DIV 8'h1a
`define PCR_RST_OUT_DIV 8'h23
`define PCR_RST_PLL_OP 8'h0c
`define PCR_RST_RSVD_A 8'h30
`define PCR_RST_EN_FREQ 8'h90
`define PCR_RST_B_STOP_LOOP 8'h84
`define PCR_RST_B_EN_FREQ 8'h80
`define PCR_RST_C_STOP 8'h80
`define PCR_RST_RSVD_B 8'hf4
`define PCR_RST_SRC_SEL 8'h8d
`define PCR_RST_PWR_FREERUN 8'h9b
`define PCR_SLAVE_ADDR 7'h09 // Bus address; the value is arbitrary.
`endif

/* File: verilog/pcr_sync2.v */
// Two-flop synchroniser for a pin level.
`default_nettype none
module pcr_sync2 (
  input wire sys_clk_in,
  input wire rst_n_in,
  input wire d_in,
  output reg q_out
);
  reg meta_r;

  // Pins idle high on the serial bus, so both stages reset high.
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_r <= 1'b1;
      q_out <= 1'b1;
    end else begin
      meta_r <= d_in;
      q_out <= meta_r;
    end
  end
endmodule
`default_nettype wire

/* File: verilog/pcr_factor.v */
// Output divider pair decoder: ratio is the product of the two selected factors.
`default_nettype none
module pcr_factor (
  input wire [3:0] field_in,
  output wire [5:0] ratio_out
);
  // Upper pair picks 1,2,4,5 and lower pair 1,3,5,10.
  function [2:0] hi_factor;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: hi_factor = 3'h1;
        2'h1: hi_factor = 3'h2;
        2'h2: hi_factor = 3'h4;
        default: hi_factor = 3'h5;
      endcase
    end
  endfunction

  function [3:0] lo_factor;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: lo_factor = 4'h1;
        2'h1: lo_factor = 4'h3;
        2'h2: lo_factor = 4'h5;
        default: lo_factor = 4'ha;
      endcase
    end
  endfunction

  wire [6:0] prod;
  assign prod = hi_factor(field_in[3:2]) * lo_factor(field_in[1:0]);
  assign ratio_out = prod[5:0];
endmodule
`default_nettype wire

/* File: verilog/pcr_regs.v */
// Second-PLL and output configuration bank behind the two-wire management bus.
`include "pcr_map.vh"
`default_nettype none
module pcr_regs #(
  parameter [6:0] SLAVE_ADDR = `PCR_SLAVE_ADDR
) (
  // Clock and reset.
  input wire sys_clk_in,
  input wire rst_n_in,
  // Two-wire management bus pins.
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe_out,
  // Second PLL spread and loop.
  output reg [7:0] spread_step_delta_out,
  output reg [9:0] spread_period_out,
  output reg spread_enable_out,
  output reg [4:0] loop_res_sel_out,
  output reg [6:0] charge_pump_scale_out,
  output reg ref_current_select_out,
  output reg ref_doubler_enable_out,
  output reg [1:0] ref_bypass_out,
  output reg [4:0] ref_divider_value_out,
  output reg [3:0] out_divider_c_out,
  output reg [3:0] out_divider_d_out,
  output reg [5:0] out_divider_ratio_out,
  output reg spread_high_res_enable_out,
  output reg pll_b_ref_select_out,
  output reg [2:0] pll_run_out,
  output reg [2:0] pll_lock_use_out,
  // Outputs and pin functions.
  output reg [2:0] output_enable_out,
  output reg [1:0] enable_pin_a_function_out,
  output reg [1:0] freq_setting_select_out,
  output reg dynamic_freq_enable_out,
  output reg [2:0] output_stoppable_out,
  output reg loop_order_select_out,
  output reg extra_pole_enable_out,
  output reg divider_e_source_out,
  output reg [5:0] output_source_out,
  output reg [1:0] divider_a_source_out,
  output reg chip_run_out,
  output reg ref_free_run_out,
  output reg free_run_both_out,
  output reg enable_pins_bc_enable_out,
  output reg [1:0] divider_d_source_out
);
  // One-hot bus states; NREG marks a pointer that falls outside the bank.
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_ADDR = 6'h02;
  localparam [5:0] ST_ACK = 6'h04;
  localparam [5:0] ST_WRITE = 6'h08;
  localparam [5:0] ST_READ = 6'h10;
  localparam [5:0] ST_RACK = 6'h20;
  localparam [3:0] NREG = 4'hf;

  // Register storage, index 0 is offset 0x16.
  reg [7:0] regs_r [0:14];
  wire scl_s;
  wire sda_s;
  reg scl_d_r;
  reg sda_d_r;
  reg [5:0] state_r;
  reg [3:0] bit_cnt_r;
  reg [7:0] shift_r;
  reg [7:0] ptr_r;
  reg ptr_set_r;
  reg rd_mode_r;
  reg wr_stb_r;
  reg [7:0] wr_data_r;
  wire [5:0] ratio;
  integer i;

  // Pin synchronisers for the serial clock and data lines.
  pcr_sync2 u_sync_scl (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .d_in(scl_in),
    .q_out(scl_s)
  );

  pcr_sync2 u_sync_sda (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .d_in(sda_in),
    .q_out(sda_s)
  );

  // Divide ratio of the first output divider field.
  pcr_factor u_factor (
    .field_in(regs_r[5][7:4]),
    .ratio_out(ratio)
  );

  // Maps a byte pointer to a bank index, out of range gives NREG.
  function [3:0] idx_of;
    input [7:0] p;
    begin
      if (p >= `PCR_OFF_FIRST && p <= `PCR_OFF_LAST) begin
        idx_of = p[3:0] - 4'h6;
        if (p[5]) idx_of = p[3:0] + 4'ha;
      end else begin
        idx_of = NREG;
      end
    end
  endfunction

  // Edge and start/stop detectors on the synchronised pins, plus the read mux.
  wire scl_rise = scl_s & ~scl_d_r;
  wire scl_fall = ~scl_s & scl_d_r;
  wire start_c = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_c = scl_s & scl_d_r & ~sda_d_r & sda_s;
  wire [3:0] ptr_idx = idx_of(ptr_r);
  wire [7:0] rd_byte = (ptr_idx == NREG) ? 8'h00 : regs_r[ptr_idx];

  // Serial slave: address, pointer byte, then data bytes with auto-increment.
  // Sampling on synchronised edges needs SCL well below a tenth of the clock rate.
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      state_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      ptr_r <= 8'h00;
      ptr_set_r <= 1'b0;
      rd_mode_r <= 1'b0;
      wr_stb_r <= 1'b0;
      wr_data_r <= 8'h00;
      sda_out <= 1'b0;
      sda_oe_out <= 1'b0;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      wr_stb_r <= 1'b0;
      if (start_c) begin
        state_r <= ST_ADDR;
        bit_cnt_r <= 4'h0;
        ptr_set_r <= 1'b0;
        sda_oe_out <= 1'b0;
      end else if (stop_c) begin
        state_r <= ST_IDLE;
        sda_oe_out <= 1'b0;
      end else begin
        case (state_r)
          ST_IDLE: begin
            sda_oe_out <= 1'b0;
          end
          ST_ADDR, ST_WRITE: begin
            if (scl_rise) begin
              shift_r <= {shift_r[6:0], sda_s};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall && bit_cnt_r == 4'h8) begin
              bit_cnt_r <= 4'h0;
              if (state_r == ST_ADDR) begin
                if (shift_r[7:1] == SLAVE_ADDR) begin
                  rd_mode_r <= shift_r[0];
                  sda_oe_out <= 1'b1;
                  state_r <= ST_ACK;
                end else begin
                  state_r <= ST_IDLE;
                end
              end else begin
                if (!ptr_set_r) begin
                  ptr_r <= shift_r;
                  ptr_set_r <= 1'b1;
                end else begin
                  wr_stb_r <= 1'b1;
                  wr_data_r <= shift_r;
                end
                sda_oe_out <= 1'b1;
                state_r <= ST_ACK;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (rd_mode_r) begin
                shift_r <= rd_byte;
                sda_oe_out <= ~rd_byte[7];
                bit_cnt_r <= 4'h1;
                state_r <= ST_READ;
              end else begin
                sda_oe_out <= 1'b0;
                state_r <= ST_WRITE;
              end
            end
          end
          ST_READ: begin
            if (scl_fall) begin
              if (bit_cnt_r == 4'h8) begin
                sda_oe_out <= 1'b0;
                ptr_r <= ptr_r + 8'h01;
                state_r <= ST_RACK;
              end else begin
                sda_oe_out <= ~shift_r[6];
                shift_r <= {shift_r[6:0], 1'b0};
                bit_cnt_r <= bit_cnt_r + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              state_r <= sda_s ? ST_IDLE : ST_ACK;
            end
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
      end
      // Step the pointer after every stored data byte, inside the bank or not.
      if (wr_stb_r) begin
        ptr_r <= ptr_r + 8'h01;
      end
    end
  end

  // Bank writes; every bit, reserved ones too, stores and reads back as written.
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      regs_r[0] <= `PCR_RST_STEP_DELTA;
      regs_r[1] <= `PCR_RST_PERIOD_LOW;
      regs_r[2] <= `PCR_RST_PLL_B_CTRL;
      regs_r[3] <= `PCR_RST_CHARGE_PUMP;
      regs_r[4] <= `PCR_RST_REF_DIV;
      regs_r[5] <= `PCR_RST_OUT_DIV;
      regs_r[6] <= `PCR_RST_PLL_OP;
      regs_r[7] <= `PCR_RST_RSVD_A;
      regs_r[8] <= `PCR_RST_EN_FREQ;
      regs_r[9] <= `PCR_RST_B_STOP_LOOP;
      regs_r[10] <= `PCR_RST_B_EN_FREQ;
      regs_r[11] <= `PCR_RST_C_STOP;
      regs_r[12] <= `PCR_RST_RSVD_B;
      regs_r[13] <= `PCR_RST_SRC_SEL;
      regs_r[14] <= `PCR_RST_PWR_FREERUN;
    end else begin
      // A pointer outside the bank matches no index, so its data falls away.
      for (i = 0; i < 15; i = i + 1) begin
        if (wr_stb_r && ptr_idx == i[3:0]) begin
          regs_r[i] <= wr_data_r;
        end
      end
    end
  end

  // Field outputs, registered so each is a flop copy of its bank bits, except the ratio, which is a flop copy of the decoded product.
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      spread_step_delta_out <= 8'h00;
      spread_period_out <= 10'h000;
      spread_enable_out <= 1'b0;
      loop_res_sel_out <= 5'h0e;
      charge_pump_scale_out <= 7'h0a;
      ref_current_select_out <= 1'b0;
      ref_doubler_enable_out <= 1'b0;
      ref_bypass_out <= 2'h0;
      ref_divider_value_out <= 5'h1a;
      out_divider_c_out <= 4'h2;
      out_divider_d_out <= 4'h3;
      out_divider_ratio_out <= 6'h05;
      spread_high_res_enable_out <= 1'b0;
      pll_b_ref_select_out <= 1'b0;
      pll_run_out <= 3'h2;
      pll_lock_use_out <= 3'h2;
      output_enable_out <= 3'h7;
      enable_pin_a_function_out <= 2'h0;
      freq_setting_select_out <= 2'h0;
      dynamic_freq_enable_out <= 1'b0;
      output_stoppable_out <= 3'h7;
      loop_order_select_out <= 1'b1;
      extra_pole_enable_out <= 1'b0;
      divider_e_source_out <= 1'b0;
      output_source_out <= 6'h23;
      divider_a_source_out <= 2'h1;
      chip_run_out <= 1'b1;
      ref_free_run_out <= 1'b0;
      free_run_both_out <= 1'b0;
      enable_pins_bc_enable_out <= 1'b0;
      divider_d_source_out <= 2'h3;
    end else begin
      spread_step_delta_out <= regs_r[0];
      spread_period_out <= {regs_r[2][7:6], regs_r[1]};
      spread_enable_out <= regs_r[2][5];
      loop_res_sel_out <= regs_r[2][4:0];
      charge_pump_scale_out <= regs_r[3][7:1];
      ref_current_select_out <= regs_r[3][0];
      ref_doubler_enable_out <= regs_r[4][7];
      ref_bypass_out <= regs_r[4][6:5];
      ref_divider_value_out <= regs_r[4][4:0];
      out_divider_c_out <= regs_r[5][7:4];
      out_divider_d_out <= regs_r[5][3:0];
      out_divider_ratio_out <= ratio;
      spread_high_res_enable_out <= regs_r[6][7];
      pll_b_ref_select_out <= regs_r[6][6];
      pll_run_out <= {regs_r[6][5], regs_r[6][3], regs_r[6][1]};
      pll_lock_use_out <= {regs_r[6][4], regs_r[6][2], regs_r[6][0]};
      output_enable_out <= {regs_r[8][4], regs_r[10][7], regs_r[8][7]};
      enable_pin_a_function_out <= regs_r[8][6:5];
      freq_setting_select_out <= regs_r[8][1:0];
      dynamic_freq_enable_out <= regs_r[10][4];
      output_stoppable_out <= {regs_r[11][7], regs_r[9][7], regs_r[14][3]};
      loop_order_select_out <= regs_r[9][2];
      extra_pole_enable_out <= regs_r[9][0];
      divider_e_source_out <= regs_r[9][1];
      output_source_out <= regs_r[13][7:2];
      divider_a_source_out <= regs_r[13][1:0];
      chip_run_out <= regs_r[14][7];
      ref_free_run_out <= regs_r[14][6];
      free_run_both_out <= regs_r[14][5];
      enable_pins_bc_enable_out <= regs_r[14][2];
      divider_d_source_out <= regs_r[14][1:0];
    end
  end
endmodule
`default_nettype wire

/* File: bench/pcr_properties.sv */
// Concurrent checks on the configuration bank ports.
`default_nettype none
module pcr_props (
  // Clock, reset and bus pins.
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  // Field outputs under watch.
  input wire logic [7:0] spread_step_delta_out,
  input wire logic [9:0] spread_period_out,
  input wire logic [4:0] loop_res_sel_out,
  input wire logic [6:0] charge_pump_scale_out,
  input wire logic [4:0] ref_divider_value_out,
  input wire logic [3:0] out_divider_c_out,
  input wire logic [5:0] out_divider_ratio_out,
  input wire logic [2:0] pll_run_out,
  input wire logic [2:0] pll_lock_use_out,
  input wire logic [2:0] output_enable_out,
  input wire logic [2:0] output_stoppable_out,
  input wire logic [5:0] output_source_out,
  input wire logic [1:0] divider_d_source_out,
  input wire logic chip_run_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Ratio of a divider field: upper pair picks 1,2,4,5 and lower pair 1,3,5,10.
  function automatic logic [5:0] prod(input logic [3:0] f);
    logic [5:0] h;
    logic [5:0] l;
    h = (f[3:2] == 2'h0) ? 6'h1 : (f[3:2] == 2'h1) ? 6'h2 : (f[3:2] == 2'h2) ? 6'h4 : 6'h5;
    l = (f[1:0] == 2'h0) ? 6'h1 : (f[1:0] == 2'h1) ? 6'h3 : (f[1:0] == 2'h2) ? 6'h5 : 6'ha;
    prod = h * l;
  endfunction
  a_reset_spread: assert property ($rose(rst_n_in) |-> spread_step_delta_out == 8'h00 &&
    spread_period_out == 10'h000 && loop_res_sel_out == 5'h0e && charge_pump_scale_out == 7'h0a)
    else $error("spread fields not at defaults after reset");
  a_reset_pll_bits: assert property ($rose(rst_n_in) |-> pll_run_out == 3'h2 &&
    pll_lock_use_out == 3'h2 && ref_divider_value_out == 5'h1a)
    else $error("pll run or lock defaults wrong");
  a_reset_outputs: assert property ($rose(rst_n_in) |-> output_enable_out == 3'h7 &&
    output_stoppable_out == 3'h7 && chip_run_out && output_source_out == 6'h23 &&
    divider_d_source_out == 2'h3)
    else $error("output defaults wrong after reset");
  a_ratio_product: assert property (out_divider_ratio_out == prod(out_divider_c_out))
    else $error("divider ratio is not the factor product");
  // A bank write lands several cycles after an SCL fall, so fields move only while SCL is low.
  a_fields_quiet: assert property (!$stable({spread_step_delta_out, pll_run_out,
    output_source_out}) |-> !scl_in && !$past(scl_in))
    else $error("field changed while clock line high");
  a_ack_holds: assert property (sda_oe_out && scl_in |=> sda_oe_out)
    else $error("data line released while clock line high");
  a_drive_on_low: assert property ($rose(sda_oe_out) |-> !scl_in && !$past(scl_in))
    else $error("data line pulled while clock line high");
  a_drive_value: assert property (sda_out == 1'b0)
    else $error("data output not held low");
endmodule
bind pcr_regs pcr_props pcr_props_i (.*);
`default_nettype wire

/* File: bench/pcr_host.sv */
// Two-wire bus host model that programs and reads the bank.
`default_nettype none
module pcr_host (
  // Clock and resolved data line.
  input wire logic sys_clk_in,
  input wire logic sda_in,
  // Driven pins; the host only ever pulls data low, the pull-up does the rest.
  output var logic scl_out,
  output var logic sda_low_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // Waits whole cycles; every pin change lands on a falling edge.
  task automatic w(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask
  // Start or repeated start: data falls while the clock line is high.
  task automatic start_c();
    sda_low_out = 1'b0;
    w(10);
    scl_out = 1'b1;
    w(10);
    sda_low_out = 1'b1;
    w(10);
    scl_out = 1'b0;
    w(5);
  endtask
  task automatic stop_c();
    sda_low_out = 1'b1;
    w(10);
    scl_out = 1'b1;
    w(10);
    sda_low_out = 1'b0;
    w(10);
  endtask
  // One bit slot: ten cycles low, ten high, sampled mid-high for margin on both sides.
  task automatic slot(input logic b, output logic s);
    sda_low_out = !b;
    w(10);
    scl_out = 1'b1;
    w(5);
    s = sda_in;
    w(5);
    scl_out = 1'b0;
  endtask
  task automatic put(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) slot(b[i], s);
    slot(1'b1, ack);
  endtask
  task automatic get(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) slot(1'b1, b[i]);
    slot(last, s);
  endtask
endmodule
`default_nettype wire

/* File: bench/tb_pcr_regs.sv */
// Self-checking bench for the second-PLL and output configuration bank.
`include "pcr_map.vh"
`default_nettype none
module tb_pcr_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_in, rst_n_in, sda_low;
  wire logic scl_in, sda_out, sda_oe_out, spread_enable_out, ref_current_select_out;
  wire logic ref_doubler_enable_out, spread_high_res_enable_out, pll_b_ref_select_out;
  wire logic dynamic_freq_enable_out, loop_order_select_out, extra_pole_enable_out;
  wire logic divider_e_source_out, chip_run_out, ref_free_run_out, free_run_both_out;
  wire logic enable_pins_bc_enable_out;
  wire logic [1:0] ref_bypass_out, enable_pin_a_function_out, freq_setting_select_out;
  wire logic [1:0] divider_a_source_out, divider_d_source_out;
  wire logic [2:0] pll_run_out, pll_lock_use_out, output_enable_out, output_stoppable_out;
  wire logic [3:0] out_divider_c_out, out_divider_d_out;
  wire logic [4:0] loop_res_sel_out, ref_divider_value_out;
  wire logic [5:0] out_divider_ratio_out, output_source_out;
  wire logic [6:0] charge_pump_scale_out;
  wire logic [7:0] spread_step_delta_out;
  wire logic [9:0] spread_period_out;
  // Open-drain data line with pull-up: low when either party pulls.
  wire logic sda_in = !(sda_low || sda_oe_out);
  logic [7:0] dflt [15] = '{8'h00, 8'h00, 8'h0e, 8'h14, 8'h1a, 8'h23, 8'h0c, 8'h30,
    8'h90, 8'h84, 8'h80, 8'h80, 8'hf4, 8'h8d, 8'h9b};
  logic [7:0] used [15] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00,
    8'hf3, 8'h87, 8'h90, 8'h80, 8'h00, 8'hff, 8'hef};
  logic [7:0] e [15];
  logic [7:0] r [15];
  int fails, checks_done, cyc;
  pcr_regs pcr_regs_i (.*);
  pcr_host pcr_host_i (.sys_clk_in, .sda_in, .scl_out(scl_in), .sda_low_out(sda_low));
  initial begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end
  // Hang guard: the whole run needs roughly 13000 cycles.
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      report_and_stop();
    end
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Burst write of e[k] onward from pointer p.
  task automatic wr(input logic [7:0] p, input int k, input int n);
    logic a;
    pcr_host_i.start_c();
    pcr_host_i.put({`PCR_SLAVE_ADDR, 1'b0}, a);
    pcr_host_i.put(p, a);
    for (int i = k; i < k + n; i++) pcr_host_i.put(e[i], a);
    chk("write ack", a, 1'b0);
    pcr_host_i.stop_c();
  endtask
  // Burst read of n bytes from pointer p into r.
  task automatic rd(input logic [7:0] p, input int n);
    logic a;
    pcr_host_i.start_c();
    pcr_host_i.put({`PCR_SLAVE_ADDR, 1'b0}, a);
    pcr_host_i.put(p, a);
    pcr_host_i.start_c();
    pcr_host_i.put({`PCR_SLAVE_ADDR, 1'b1}, a);
    chk("read ack", a, 1'b0);
    for (int i = 0; i < n; i++) pcr_host_i.get(i == n - 1, r[i]);
    pcr_host_i.stop_c();
  endtask
  task automatic s_defaults();
    rd(`PCR_OFF_FIRST, 15);
    for (int i = 0; i < 15; i++) chk("default", r[i], dflt[i]);
  endtask
  task automatic s_write_all();
    for (int i = 0; i < 15; i++) e[i] = dflt[i] ^ used[i];
    wr(`PCR_OFF_FIRST, 0, 15);
    chk("step", spread_step_delta_out, e[0]);
    chk("period", spread_period_out, {e[2][7:6], e[1]});
    chk("spread on", spread_enable_out, e[2][5]);
    chk("loop res", loop_res_sel_out, e[2][4:0]);
    chk("pump", {charge_pump_scale_out, ref_current_select_out}, e[3]);
    chk("ref div", {ref_doubler_enable_out, ref_bypass_out, ref_divider_value_out}, e[4]);
    chk("out div", {out_divider_c_out, out_divider_d_out}, e[5]);
    chk("ratio", out_divider_ratio_out, 6'h0f);
    chk("hires", {spread_high_res_enable_out, pll_b_ref_select_out}, e[6][7:6]);
    chk("pll", {pll_run_out, pll_lock_use_out}, {e[6][5], e[6][3], e[6][1], e[6][4], e[6][2],
      e[6][0]});
    chk("enables", {output_enable_out, enable_pin_a_function_out}, {e[8][4], e[10][7], e[8][7],
      e[8][6:5]});
    chk("freq", {freq_setting_select_out, dynamic_freq_enable_out}, {e[8][1:0], e[10][4]});
    chk("stoppable", output_stoppable_out, {e[11][7], e[9][7], e[14][3]});
    chk("loop", {loop_order_select_out, divider_e_source_out, extra_pole_enable_out},
      e[9][2:0]);
    chk("sources", {output_source_out, divider_a_source_out}, e[13]);
    chk("power", {chip_run_out, ref_free_run_out, free_run_both_out, enable_pins_bc_enable_out,
      divider_d_source_out}, {e[14][7:5], e[14][2:0]});
    rd(`PCR_OFF_FIRST, 15);
    for (int i = 0; i < 15; i++) chk("readback", r[i], e[i]);
  endtask
  // Foreign address is ignored; below the bank a write is dropped and a read gives zero.
  task automatic s_refused();
    logic a;
    pcr_host_i.start_c();
    pcr_host_i.put({`PCR_SLAVE_ADDR ^ 7'h01, 1'b0}, a);
    chk("foreign ack", a, 1'b1);
    pcr_host_i.stop_c();
    e[0] = 8'h3c;
    e[1] = 8'h5a;
    wr(8'h15, 0, 2);
    rd(8'h15, 3);
    chk("outside", r[0], 8'h00);
    chk("step in", r[1], 8'h5a);
    chk("no spill", r[2], 8'hff);
    chk("step out", spread_step_delta_out, 8'h5a);
  endtask
  task automatic s_reset_again();
    rst_n_in = 1'b0;
    repeat (2) @(negedge sys_clk_in);
    rst_n_in = 1'b1;
    repeat (5) @(negedge sys_clk_in);
    rd(`PCR_OFF_PLL_OP, 1);
    chk("pll op", r[0], 8'h0c);
    chk("chip run", chip_run_out, 1'b1);
  endtask
  initial begin
    rst_n_in = 1'b0;
    fails = 0;
    checks_done = 0;
    cyc = 0;
    repeat (3) @(negedge sys_clk_in);
    rst_n_in = 1'b1;
    repeat (5) @(negedge sys_clk_in);
    s_defaults();
    s_write_all();
    s_refused();
    s_reset_again();
    report_and_stop();
  end
endmodule
`default_nettype wire
